// ---- core/rtmcs_pkg.sv ----
// Purpose: constants shared by the mode code and status block.
// Assumes: one 125 MHz clock, synchronous active-high reset.
// Notes: register bit positions, reset values and mode codes.
package rtmcs_pkg;

    localparam int WORD_W = 16;
    localparam int FIELD_W = 5;
    localparam int LAST_CMD_LOW_W = 11;

    // System status register bit positions.
    localparam int SYS_SEL_BIT = 5;
    localparam int SYS_CHAN_A_BIT = 6;
    localparam int SYS_CHB_EN_BIT = 7;
    localparam int SYS_CHA_EN_BIT = 8;
    localparam int SYS_TF_ALLOWED_BIT = 9;
    localparam int SYS_BUSY_BIT = 10;
    localparam int SYS_SELF_TEST_BIT = 11;
    localparam int SYS_PARITY_BIT = 12;
    localparam int SYS_MSG_ERR_BIT = 13;
    localparam int SYS_GOOD_MSG_BIT = 14;
    localparam int SYS_ACTIVE_BIT = 15;

    // Last command register bit positions.
    localparam int LC_BUSY_BIT = 11;
    localparam int LC_SELF_TEST_BIT = 12;
    localparam int LC_TF_ALLOWED_BIT = 13;
    localparam int LC_CHAN_A_BIT = 14;
    localparam int LC_ILLEGAL_BIT = 15;

    // Reset values.
    localparam logic RST_CHAN_A = 1'b1;
    localparam logic RST_TF_ALLOWED = 1'b1;
    localparam logic RST_ILLEGAL = 1'b1;
    localparam logic [10:0] RST_LAST_CMD_LOW = 11'h7ff;
    localparam logic [4:0] RST_FIELD = 5'h00;

    // Command word fields and subaddress markers.
    localparam logic [4:0] SA_MODE_LO = 5'h00;
    localparam logic [4:0] SA_MODE_HI = 5'h1f;
    localparam logic [4:0] ADDR_BROADCAST = 5'h1f;

    // Mode codes.
    localparam logic [4:0] MC_DYN_BUS = 5'h00;
    localparam logic [4:0] MC_SYNC = 5'h01;
    localparam logic [4:0] MC_TX_STATUS = 5'h02;
    localparam logic [4:0] MC_SELF_TEST = 5'h03;
    localparam logic [4:0] MC_TX_SHUT = 5'h04;
    localparam logic [4:0] MC_OVR_TX_SHUT = 5'h05;
    localparam logic [4:0] MC_INH_TF = 5'h06;
    localparam logic [4:0] MC_OVR_INH_TF = 5'h07;
    localparam logic [4:0] MC_RESET_RT = 5'h08;
    localparam logic [4:0] MC_RSV1_LO = 5'h09;
    localparam logic [4:0] MC_RSV1_HI = 5'h0f;
    localparam logic [4:0] MC_TX_VECTOR = 5'h10;
    localparam logic [4:0] MC_SYNC_DATA = 5'h11;
    localparam logic [4:0] MC_TX_LAST = 5'h12;
    localparam logic [4:0] MC_TX_BIT = 5'h13;
    localparam logic [4:0] MC_SEL_SHUT = 5'h14;
    localparam logic [4:0] MC_OVR_SEL_SHUT = 5'h15;
    localparam logic [4:0] MC_RSV2_LO = 5'h16;
    localparam logic [4:0] MC_DATA_FLAG = 5'h10;

    // Data page block used by mode codes with data.
    localparam logic [7:0] MODE_DATA_BLOCK = 8'h01;

    typedef enum logic [1:0] {
        RESP_IDLE,
        RESP_STATUS,
        RESP_LAST_CMD
    } rtmcs_resp_t;

endpackage : rtmcs_pkg

// ---- core/rtmcs_stream_if.sv ----
// Purpose: word stream between the responder and the output buffer.
// Assumes: single clock domain.
// Notes: valid and ready handshake, word taken when both are high.
`timescale 1ns/1ps
`default_nettype none
interface rtmcs_stream_if;
    logic [15:0] data;
    logic valid;
    logic ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface : rtmcs_stream_if
`default_nettype wire

// ---- core/rtmcs_word_buf.sv ----
// Purpose: two-entry buffer in front of the encoder.
// Assumes: synchronous active-high reset.
// Notes: a stall by the encoder loses no word.
`timescale 1ns/1ps
`default_nettype none
module rtmcs_word_buf #(
    parameter int WIDTH = 16
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Filling side.
    rtmcs_stream_if.snk inPort,
    // Draining side.
    output logic [WIDTH-1:0] outData,
    output logic outValid,
    input wire logic outReady
);
    logic [WIDTH-1:0] slot0;
    logic [WIDTH-1:0] slot1;
    logic [1:0] count;
    logic [WIDTH-1:0] next_slot0;
    logic [WIDTH-1:0] next_slot1;
    logic [1:0] next_count;
    logic doPush;
    logic doPop;

    assign inPort.ready = (count != 2'd2);
    assign outValid = (count != 2'd0);
    assign outData = slot0;
    assign doPush = inPort.valid && inPort.ready;
    assign doPop = outValid && outReady;

    always_comb begin
        next_slot0 = slot0;
        next_slot1 = slot1;
        next_count = count;
        if (doPop) begin
            next_slot0 = slot1;
        end
        if (doPush) begin
            if ((count == 2'd0) || (count == 2'd1 && doPop)) begin
                next_slot0 = inPort.data;
            end else begin
                next_slot1 = inPort.data;
            end
        end
        if (doPush && !doPop) begin
            next_count = count + 2'd1;
        end else if (doPop && !doPush) begin
            next_count = count - 2'd1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            slot0 <= '0;
            slot1 <= '0;
            count <= 2'd0;
        end else begin
            slot0 <= next_slot0;
            slot1 <= next_slot1;
            count <= next_count;
        end
    end
endmodule : rtmcs_word_buf
`default_nettype wire

// ---- core/rtmcs_top.sv ----
// Purpose: mode code decode, status registers and response sequencing.
// Assumes: inputs synchronous to clk; decoder delivers validated words.
// Notes: host reads the two read-only registers over select pins.
`timescale 1ns/1ps
`default_nettype none
module rtmcs_top (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Validated command words from the decoders.
    input wire logic cmdStrobe,
    input wire logic [15:0] cmdWord,
    input wire logic cmdOnChannelA,
    // Message outcome events from the transfer logic.
    input wire logic goodMsgEvent,
    input wire logic msgErrorCond,
    // Host register pins.
    input wire logic chip_select_n,
    input wire logic register_select_n,
    input wire logic addrIn0,
    input wire logic read_not_write,
    output logic [15:0] hostDataOut,
    output logic hostDataOe_n,
    // Control and terminal state from elsewhere in the device.
    input wire logic [4:0] terminalAddress,
    input wire logic address_parity_fault,
    input wire logic channelAEnable,
    input wire logic channelBEnable,
    input wire logic systemBusy,
    input wire logic selfTestActive,
    input wire logic hostTermFlag,
    input wire logic subsystemBusy,
    input wire logic serviceRequest,
    input wire logic tx_active_n,
    input wire logic rx_active_n,
    // External illegal command decode.
    input wire logic illegal_command_in,
    // Decode outputs.
    output logic [4:0] command_field_out,
    output logic modecode_or_subaddr_sel,
    output logic broadcast_out,
    output logic msg_fault_out,
    output logic channelAShutdown,
    output logic channelBShutdown,
    output logic dmaRequest,
    output logic [7:0] dmaBlock,
    // Words to the encoder.
    output logic [15:0] txWord,
    output logic txWordValid,
    input wire logic txWordReady
);
    rtmcs_stream_if respStream ();

    logic [4:0] field;
    logic fieldSel;
    logic chanA;
    logic tfAllowed;
    logic msgErrLatch;
    logic goodMsg;
    logic errClearPending;
    logic [10:0] lastCmdLow;
    logic lastIllegal;
    logic statusMe;
    logic statusBcast;
    logic bcast;
    logic faultOut;
    logic shutA;
    logic shutB;
    logic dmaReq;
    logic [7:0] dmaBlk;
    logic [15:0] dataOut;
    logic dataOe_n;
    logic readHeld;
    logic lastPending;
    rtmcs_pkg::rtmcs_resp_t respState;

    logic [4:0] next_field;
    logic next_fieldSel;
    logic next_chanA;
    logic next_tfAllowed;
    logic next_msgErrLatch;
    logic next_goodMsg;
    logic next_errClearPending;
    logic [10:0] next_lastCmdLow;
    logic next_lastIllegal;
    logic next_statusMe;
    logic next_statusBcast;
    logic next_bcast;
    logic next_faultOut;
    logic next_shutA;
    logic next_shutB;
    logic next_dmaReq;
    logic [7:0] next_dmaBlk;
    logic [15:0] next_dataOut;
    logic next_dataOe_n;
    logic next_readHeld;
    logic next_lastPending;
    rtmcs_pkg::rtmcs_resp_t next_respState;

    logic [4:0] cmdAddr;
    logic cmdTx;
    logic [4:0] cmdSa;
    logic [4:0] cmdMc;
    logic isMode;
    logic internalIllegal;
    logic illegal;
    logic isTxLast;
    logic keepStatus;
    logic readSys;
    logic readLast;
    logic readEnd;
    logic [15:0] sysReg;
    logic [15:0] lastCmdReg;
    logic [15:0] statusWord;

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    assign cmdAddr = cmdWord[15:11];
    assign cmdTx = cmdWord[10];
    assign cmdSa = cmdWord[9:5];
    assign cmdMc = cmdWord[4:0];
    assign isMode = (cmdSa == rtmcs_pkg::SA_MODE_LO) || (cmdSa == rtmcs_pkg::SA_MODE_HI);
    assign internalIllegal = isMode && (
        (cmdTx && cmdMc == rtmcs_pkg::MC_DYN_BUS) ||
        (!cmdTx && (cmdMc == rtmcs_pkg::MC_SEL_SHUT || cmdMc == rtmcs_pkg::MC_OVR_SEL_SHUT)) ||
        (cmdMc >= rtmcs_pkg::MC_RSV1_LO && cmdMc <= rtmcs_pkg::MC_RSV1_HI) ||
        (cmdMc >= rtmcs_pkg::MC_RSV2_LO));
    assign illegal = internalIllegal || illegal_command_in;
    assign isTxLast = isMode && cmdTx && (cmdMc == rtmcs_pkg::MC_TX_LAST);
    assign keepStatus = isMode && cmdTx && (cmdMc == rtmcs_pkg::MC_TX_STATUS || isTxLast);

    // ------------------------------------------------------------
    // Register views
    // ------------------------------------------------------------
    // host read decode
    assign readSys = !chip_select_n && !register_select_n && read_not_write && !addrIn0;
    assign readLast = !chip_select_n && !register_select_n && read_not_write && addrIn0;
    assign readEnd = readHeld && !readSys;

    always_comb begin
        sysReg = '0;
        sysReg[4:0] = field;
        sysReg[rtmcs_pkg::SYS_SEL_BIT] = fieldSel;
        sysReg[rtmcs_pkg::SYS_CHAN_A_BIT] = chanA;
        sysReg[rtmcs_pkg::SYS_CHB_EN_BIT] = channelBEnable && !shutB;
        sysReg[rtmcs_pkg::SYS_CHA_EN_BIT] = channelAEnable && !shutA;
        sysReg[rtmcs_pkg::SYS_TF_ALLOWED_BIT] = tfAllowed;
        sysReg[rtmcs_pkg::SYS_BUSY_BIT] = systemBusy;
        sysReg[rtmcs_pkg::SYS_SELF_TEST_BIT] = selfTestActive;
        sysReg[rtmcs_pkg::SYS_PARITY_BIT] = address_parity_fault;
        sysReg[rtmcs_pkg::SYS_MSG_ERR_BIT] = msgErrLatch;
        sysReg[rtmcs_pkg::SYS_GOOD_MSG_BIT] = goodMsg;
        sysReg[rtmcs_pkg::SYS_ACTIVE_BIT] = !(tx_active_n && rx_active_n);
    end

    always_comb begin
        lastCmdReg[10:0] = lastCmdLow;
        lastCmdReg[rtmcs_pkg::LC_BUSY_BIT] = sysReg[rtmcs_pkg::SYS_BUSY_BIT];
        lastCmdReg[rtmcs_pkg::LC_SELF_TEST_BIT] = sysReg[rtmcs_pkg::SYS_SELF_TEST_BIT];
        lastCmdReg[rtmcs_pkg::LC_TF_ALLOWED_BIT] = sysReg[rtmcs_pkg::SYS_TF_ALLOWED_BIT];
        lastCmdReg[rtmcs_pkg::LC_CHAN_A_BIT] = sysReg[rtmcs_pkg::SYS_CHAN_A_BIT];
        lastCmdReg[rtmcs_pkg::LC_ILLEGAL_BIT] = lastIllegal;
    end

    // Status word: address, error, broadcast received, busy, subsystem, flag.
    assign statusWord = {terminalAddress, statusMe, 1'b0, serviceRequest, 3'h0,
                         statusBcast, systemBusy, subsystemBusy, 1'b0, hostTermFlag && tfAllowed};

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_field = field;
        next_fieldSel = fieldSel;
        next_chanA = chanA;
        next_tfAllowed = tfAllowed;
        next_msgErrLatch = msgErrLatch;
        next_goodMsg = goodMsg;
        next_errClearPending = errClearPending;
        next_lastCmdLow = lastCmdLow;
        next_lastIllegal = lastIllegal;
        next_statusMe = statusMe;
        next_statusBcast = statusBcast;
        next_bcast = bcast;
        next_faultOut = faultOut;
        next_shutA = shutA;
        next_shutB = shutB;
        next_dmaReq = 1'b0;
        next_dmaBlk = dmaBlk;
        next_readHeld = readSys;
        next_respState = respState;
        next_lastPending = lastPending;
        respStream.valid = 1'b0;
        respStream.data = statusWord;

        next_dataOe_n = !(readSys || readLast);
        next_dataOut = readLast ? lastCmdReg : (readSys ? sysReg : 16'h0000);

        if (readEnd) begin
            next_goodMsg = 1'b0;
            next_errClearPending = 1'b1;
        end
        if (errClearPending && !msgErrorCond && !faultOut && !address_parity_fault) begin
            next_msgErrLatch = 1'b0;
            next_errClearPending = 1'b0;
        end
        if (goodMsgEvent) begin
            next_goodMsg = 1'b1;
        end
        if (msgErrorCond || address_parity_fault) begin
            next_msgErrLatch = 1'b1;
        end

        case (respState)
            rtmcs_pkg::RESP_STATUS: begin
                respStream.valid = 1'b1;
                respStream.data = statusWord;
                if (respStream.ready) begin
                    next_respState = lastPending ? rtmcs_pkg::RESP_LAST_CMD : rtmcs_pkg::RESP_IDLE;
                    next_lastPending = 1'b0;
                end
            end
            rtmcs_pkg::RESP_LAST_CMD: begin
                respStream.valid = 1'b1;
                respStream.data = {terminalAddress, lastCmdLow};
                if (respStream.ready) begin
                    next_respState = rtmcs_pkg::RESP_IDLE;
                end
            end
            rtmcs_pkg::RESP_IDLE: begin
                next_respState = rtmcs_pkg::RESP_IDLE;
            end
            default: begin
                next_respState = rtmcs_pkg::RESP_IDLE;
            end
        endcase

        // A new command supersedes any response still being sent.
        if (cmdStrobe) begin
            next_field = isMode ? cmdMc : cmdSa;
            next_fieldSel = !isMode;
            next_chanA = cmdOnChannelA;
            next_bcast = (cmdAddr == rtmcs_pkg::ADDR_BROADCAST);
            next_lastIllegal = illegal;
            next_faultOut = illegal;
            if (illegal) begin
                next_msgErrLatch = 1'b1;
            end
            if (!isTxLast) begin
                next_lastCmdLow = cmdWord[10:0];
            end
            if (!keepStatus) begin
                next_statusMe = illegal;
                next_statusBcast = (cmdAddr == rtmcs_pkg::ADDR_BROADCAST);
            end
            // data mode codes other than transmit last command use data path
            if (!illegal && !systemBusy && (!isMode || (cmdMc >= rtmcs_pkg::MC_DATA_FLAG && !isTxLast))) begin
                next_dmaReq = 1'b1;
            end
            if (isMode) begin
                next_dmaBlk = rtmcs_pkg::MODE_DATA_BLOCK;
            end else begin
                next_dmaBlk = 8'h00;
            end
            if (isMode && cmdTx && !illegal) begin
                case (cmdMc)
                    rtmcs_pkg::MC_TX_SHUT: begin
                        next_shutA = !cmdOnChannelA;
                        next_shutB = cmdOnChannelA;
                    end
                    rtmcs_pkg::MC_OVR_TX_SHUT: begin
                        next_shutA = cmdOnChannelA ? shutA : 1'b0;
                        next_shutB = cmdOnChannelA ? 1'b0 : shutB;
                    end
                    rtmcs_pkg::MC_INH_TF: begin
                        next_tfAllowed = 1'b0;
                    end
                    rtmcs_pkg::MC_OVR_INH_TF: begin
                        next_tfAllowed = 1'b1;
                    end
                    default: begin
                        next_tfAllowed = tfAllowed;
                    end
                endcase
            end
            // Broadcast commands get no status reply on the bus.
            // The status word always leads; the last command word follows it.
            next_lastPending = isTxLast && !illegal && (cmdAddr != rtmcs_pkg::ADDR_BROADCAST);
            if (cmdAddr == rtmcs_pkg::ADDR_BROADCAST) begin
                next_respState = rtmcs_pkg::RESP_IDLE;
            end else begin
                next_respState = rtmcs_pkg::RESP_STATUS;
            end
        end
    end

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            field <= rtmcs_pkg::RST_FIELD;
            fieldSel <= 1'b0;
            chanA <= rtmcs_pkg::RST_CHAN_A;
            tfAllowed <= rtmcs_pkg::RST_TF_ALLOWED;
            msgErrLatch <= 1'b0;
            goodMsg <= 1'b0;
            errClearPending <= 1'b0;
            lastCmdLow <= rtmcs_pkg::RST_LAST_CMD_LOW;
            lastIllegal <= rtmcs_pkg::RST_ILLEGAL;
            statusMe <= 1'b0;
            statusBcast <= 1'b0;
            bcast <= 1'b0;
            faultOut <= 1'b0;
            shutA <= 1'b0;
            shutB <= 1'b0;
            dmaReq <= 1'b0;
            dmaBlk <= 8'h00;
            dataOut <= 16'h0000;
            dataOe_n <= 1'b1;
            readHeld <= 1'b0;
            lastPending <= 1'b0;
            respState <= rtmcs_pkg::RESP_IDLE;
        end else begin
            field <= next_field;
            fieldSel <= next_fieldSel;
            chanA <= next_chanA;
            tfAllowed <= next_tfAllowed;
            msgErrLatch <= next_msgErrLatch;
            goodMsg <= next_goodMsg;
            errClearPending <= next_errClearPending;
            lastCmdLow <= next_lastCmdLow;
            lastIllegal <= next_lastIllegal;
            statusMe <= next_statusMe;
            statusBcast <= next_statusBcast;
            bcast <= next_bcast;
            faultOut <= next_faultOut;
            shutA <= next_shutA;
            shutB <= next_shutB;
            dmaReq <= next_dmaReq;
            dmaBlk <= next_dmaBlk;
            dataOut <= next_dataOut;
            dataOe_n <= next_dataOe_n;
            readHeld <= next_readHeld;
            lastPending <= next_lastPending;
            respState <= next_respState;
        end
    end

    // ------------------------------------------------------------
    // Output buffer and outputs
    // ------------------------------------------------------------
    rtmcs_word_buf #(
        .WIDTH(rtmcs_pkg::WORD_W)
    ) u_word_buf (
        .clk(clk),
        .reset(reset),
        .inPort(respStream.snk),
        .outData(txWord),
        .outValid(txWordValid),
        .outReady(txWordReady)
    );

    assign command_field_out = field;
    assign modecode_or_subaddr_sel = fieldSel;
    assign broadcast_out = bcast;
    assign msg_fault_out = faultOut;
    assign channelAShutdown = shutA;
    assign channelBShutdown = shutB;
    assign dmaRequest = dmaReq;
    assign dmaBlock = dmaBlk;
    assign hostDataOut = dataOut;
    assign hostDataOe_n = dataOe_n;
endmodule : rtmcs_top
`default_nettype wire

// ---- tb/rtmcs_enc_model.sv ----
// Purpose: encoder stand-in that takes response words.
// Assumes: one clock.
// Notes: stall holds ready low, so the buffer must keep its words.
`timescale 1ns/1ps
`default_nettype none
module rtmcs_enc_model (
    input wire logic clk,
    input wire logic stall,
    input wire logic [15:0] txWord,
    input wire logic txWordValid,
    output logic txWordReady
);
    logic [15:0] seen [0:63];
    int n = 0;
    assign txWordReady = !stall;
    always @(posedge clk) begin
        if (txWordValid && txWordReady) begin
            seen[n[5:0]] <= txWord;
            n <= n + 1;
        end
    end
endmodule : rtmcs_enc_model
`default_nettype wire

// ---- tb/rtmcs_props.sv ----
// Purpose: port checks on the mode code block.
// Assumes: one clock, synchronous reset.
// Notes: bound by name onto the top module.
`timescale 1ns/1ps
`default_nettype none
module rtmcs_props (
    input wire logic clk,
    input wire logic reset,
    input wire logic cmdStrobe,
    input wire logic [15:0] cmdWord,
    input wire logic illegal_command_in,
    input wire logic systemBusy,
    input wire logic chip_select_n,
    input wire logic register_select_n,
    input wire logic addrIn0,
    input wire logic read_not_write,
    input wire logic [15:0] hostDataOut,
    input wire logic hostDataOe_n,
    input wire logic [4:0] command_field_out,
    input wire logic modecode_or_subaddr_sel,
    input wire logic msg_fault_out,
    input wire logic dmaRequest,
    input wire logic txWordValid
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (reset);
    wire logic [4:0] c = cmdWord[4:0];
    wire logic t = cmdWord[10];
    wire logic mc = cmdWord[9:5] == 5'h00 || cmdWord[9:5] == 5'h1f;
    wire logic rdp = !chip_select_n && !register_select_n && read_not_write;
    wire logic bad = mc && ((c > 5'h08 && c < 5'h10) || c > 5'h15 || (t && c == 5'h00) || (!t && c > 5'h13));
    a_field_decode: assert property (cmdStrobe |=> command_field_out == ($past(mc) ? $past(c) : $past(cmdWord[9:5])))
        else $error("field wrong");
    a_sel_decode: assert property (cmdStrobe |=> modecode_or_subaddr_sel == !$past(mc))
        else $error("selector wrong");
    a_read_drive: assert property (rdp |=> !hostDataOe_n)
        else $error("read not driven");
    a_sys_low: assert property (rdp && !addrIn0 |=> hostDataOut[5:0] == $past({modecode_or_subaddr_sel, command_field_out}))
        else $error("status low bits");
    a_illegal_fault: assert property (cmdStrobe && (bad || illegal_command_in) |=> msg_fault_out)
        else $error("no fault");
    a_no_dma: assert property (cmdStrobe && mc && t && (c == 5'h02 || c == 5'h12) |=> !dmaRequest)
        else $error("dma on internal code");
    a_mode_dma: assert property (cmdStrobe && mc && !t && c == 5'h11 && !illegal_command_in && !systemBusy |=> dmaRequest)
        else $error("no dma");
    a_status_sent: assert property (cmdStrobe && mc && t && c == 5'h01 && cmdWord[15:11] != 5'h1f |=> ##[1:8] txWordValid)
        else $error("no status");
endmodule : rtmcs_props
bind rtmcs_top rtmcs_props chk (.*);
`default_nettype wire

// ---- tb/testbench.sv ----
// Purpose: self-checking bench.
// Assumes: inputs move on the rising edge.
// Notes: response order is judged status first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic [4:0] TA = 5'h05;
    logic clk = 0, reset = 1, cmdStrobe = 0, cmdOnChannelA = 1, goodMsgEvent = 0, msgErrorCond = 0, stall = 0;
    logic chip_select_n = 1, register_select_n = 1, addrIn0 = 0, read_not_write = 1, address_parity_fault = 0;
    logic systemBusy = 0, selfTestActive = 0, channelAEnable = 0, channelBEnable = 0, hostTermFlag = 0;
    logic subsystemBusy = 0, serviceRequest = 0, tx_active_n = 1, rx_active_n = 1, illegal_command_in = 0;
    logic hostDataOe_n, modecode_or_subaddr_sel, broadcast_out, msg_fault_out, channelAShutdown;
    logic channelBShutdown, dmaRequest, txWordValid, txWordReady;
    logic [15:0] cmdWord = 16'h0000, hostDataOut, txWord, w;
    logic [4:0] command_field_out, terminalAddress = TA, ad = TA;
    logic [7:0] dmaBlock;
    int n_fail = 0, checks_done = 0, cycles = 0, b;
    always #4 clk = ~clk;
    rtmcs_top uut (.*);
    rtmcs_enc_model enc (.*);
    task chk(input string nm, input logic [15:0] e, s);
        checks_done++;
        if (s !== e) begin
            n_fail++;
            $display("BAD %s exp %h got %h", nm, e, s);
        end
    endtask : chk
    task send(input logic t, input logic [4:0] sa, mc, input logic ch);
        w = {ad, t, sa, mc};
        @(posedge clk);
        cmdStrobe <= 1;
        cmdWord <= w;
        cmdOnChannelA <= ch;
        @(posedge clk);
        cmdStrobe <= 0;
        repeat (8) @(posedge clk);
    endtask : send
    task rd(input logic a, input logic [15:0] m, e, input string nm);
        @(posedge clk);
        {chip_select_n, register_select_n, addrIn0} <= {2'b00, a};
        repeat (2) @(posedge clk);
        chk(nm, e, hostDataOut & m);
        {chip_select_n, register_select_n} <= 2'b11;
        @(posedge clk);
    endtask : rd
    task t_txlast;
        b = enc.n;
        stall <= 1;
        send(1, 5'h00, 5'h12, 1);
        stall <= 0;
        repeat (6) @(posedge clk);
        chk("words", 16'(b + 2), 16'(enc.n));
        chk("word1", {TA, 11'h000}, enc.seen[6'(b)]);
        chk("word2", {TA, 11'h7ff}, enc.seen[6'(b + 1)]);
        $display("t_txlast done");
    endtask : t_txlast
    task t_ill;
        logic [5:0] ill [6] = '{6'h20, 6'h14, 6'h15, 6'h09, 6'h36, 6'h1f};
        for (int i = 0; i < 7; i++) begin
            illegal_command_in <= (i == 6);
            if (i < 6)
                send(ill[i][5], i[0] ? 5'h1f : 5'h00, ill[i][4:0], 1);
            else
                send(0, 5'h03, 5'h02, 1);
            illegal_command_in <= 0;
            rd(1, 16'h87ff, {5'h10, w[10:0]}, "lc_ill");
            rd(0, 16'h2000, 16'h2000, "me_latch");
        end
        b = enc.n;
        send(1, 5'h00, 5'h02, 1);
        chk("st_keep", {TA, 11'h400}, enc.seen[6'(b)]);
        $display("t_ill done");
    endtask : t_ill
    task t_ok;
        logic [5:0] ok [4] = '{6'h21, 6'h23, 6'h28, 6'h11};
        for (int i = 0; i < 5; i++) begin
            if (i < 4)
                send(ok[i][5], 5'h00, ok[i][4:0], 1);
            else
                send(0, 5'h07, 5'h02, 1);
            rd(1, 16'h87ff, {5'h00, w[10:0]}, "lc_ok");
            chk("dma_blk", (i < 4) ? 16'h0001 : 16'h0000, {8'h00, dmaBlock});
            rd(0, 16'h003f, (i < 4) ? {11'h000, w[4:0]} : {11'h001, w[9:5]}, "sys_low");
        end
        $display("t_ok done");
    endtask : t_ok
    task t_mode;
        send(1, 5'h00, 5'h06, 1);
        rd(0, 16'h0200, 16'h0000, "tf_off");
        rd(1, 16'h2000, 16'h0000, "lc_tf");
        send(1, 5'h00, 5'h07, 1);
        rd(0, 16'h0200, 16'h0200, "tf_on");
        send(1, 5'h00, 5'h04, 1);
        chk("shut_b", 16'h0001, {15'h0000, channelBShutdown});
        send(1, 5'h00, 5'h05, 1);
        chk("shut_b", 16'h0000, {15'h0000, channelBShutdown});
        send(1, 5'h00, 5'h04, 0);
        chk("shut_a", 16'h0001, {15'h0000, channelAShutdown});
        send(1, 5'h00, 5'h05, 0);
        chk("shut_a", 16'h0000, {15'h0000, channelAShutdown});
        ad = 5'h1f;
        b = enc.n;
        send(1, 5'h00, 5'h01, 1);
        ad = TA;
        chk("bcast", 16'h0001, {15'h0000, broadcast_out});
        chk("bc_quiet", 16'(b), 16'(enc.n));
        send(1, 5'h00, 5'h01, 0);
        rd(1, 16'h4000, 16'h0000, "lc_chan");
        chk("bcast", 16'h0000, {15'h0000, broadcast_out});
        $display("t_mode done");
    endtask : t_mode
    task t_stat;
        {systemBusy, selfTestActive, channelAEnable, channelBEnable, tx_active_n} <= 5'h1e;
        {hostTermFlag, subsystemBusy, serviceRequest, goodMsgEvent, msgErrorCond} <= 5'h1f;
        @(posedge clk);
        {goodMsgEvent, msgErrorCond} <= 2'h0;
        rd(0, 16'hed80, 16'hed80, "sys_in");
        rd(1, 16'h1800, 16'h1800, "lc_busy");
        rd(0, 16'h6000, 16'h0000, "ev_clr");
        $display("t_stat done");
    endtask : t_stat
    task close_out;
        $display("checks %0d fails %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : close_out
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            close_out();
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        reset <= 0;
        rd(0, 16'hffff, 16'h0240, "sys_rst");
        rd(1, 16'hffff, 16'he7ff, "lc_rst");
        $display("t_reset done");
        t_txlast();
        t_ill();
        t_ok();
        t_mode();
        t_stat();
        close_out();
    end
endmodule : testbench
`default_nettype wire
